// ### src/helr_pkg.sv
/*
 * shared constants, register map and carriers for the error log and report block.
 * assumes a single 40 MHz core clock and an APB slave port with 32-bit data.
 */
`default_nettype none
package helr_pkg;
    localparam int NSRC = 4;
    localparam int SRCW = 2;
    localparam int INFOW = 16;
    localparam int CNTW = 16;

    // error class codes carried by the bank log
    localparam logic [1:0] CLS_NONE = 2'h0;
    localparam logic [1:0] CLS_CORR = 2'h1;
    localparam logic [1:0] CLS_UNC = 2'h2;
    localparam logic [1:0] CLS_DEF = 2'h3;

    // register byte offsets
    localparam logic [7:0] OFS_LOG_EN = 8'h00;
    localparam logic [7:0] OFS_RPT_EN = 8'h04;
    localparam logic [7:0] OFS_ACT_DIS = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_THRESH = 8'h14;
    localparam logic [7:0] OFS_CORR_CNT = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1C;
    localparam logic [7:0] OFS_BANK0 = 8'h20;

    // bank log word fields
    localparam int LOG_VALID_BIT = 31;
    localparam int LOG_POISON_BIT = 30;
    localparam int LOG_OVF_BIT = 29;
    localparam int LOG_CLS_LSB = 16;

    // interrupt status bits
    localparam int IRQ_DEF_BIT = 0;
    localparam int IRQ_THR_BIT = 1;
    localparam int IRQ_UNC_BIT = 2;
    localparam int IRQW = 3;

    // control register bits
    localparam int CTRL_DEF_EN_BIT = 0;
    localparam int CTRL_THR_EN_BIT = 1;
    localparam int CTRL_SHUT_EN_BIT = 2;

    localparam logic [NSRC-1:0] EN_RST = 4'h0;
    localparam logic [CNTW-1:0] THRESH_RST = 16'hFFFF;

    // one detected error from a checker
    typedef struct packed {
        logic valid;
        logic correctable;
        logic deferrable;
        logic fatal;
        logic [INFOW-1:0] info;
    } helr_err_t;

    // consumption of data that carries a deferred error
    typedef struct packed {
        logic valid;
        logic [SRCW-1:0] src;
    } helr_use_t;

    // per-source action towards the checker
    typedef struct packed {
        logic correct;
        logic contain;
    } helr_act_t;
endpackage
`default_nettype wire

// ### src/helr_log_mem.sv
/*
 * bank log storage: one word per error source, registered read data.
 * assumes the writer and reader share the core clock; cleared only by cold reset.
 */
`default_nettype none
module helr_log_mem
(
    // clock and cold reset
    input wire logic clk_i,
    input wire logic cold_n_i,
    // write port
    input wire logic we_i,
    input wire logic [helr_pkg::SRCW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    // read port
    input wire logic [helr_pkg::SRCW-1:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_reg [helr_pkg::NSRC];

    // storage ignores warm reset so logs survive it
    always_ff @(posedge clk_i)
    begin
        if (!cold_n_i)
        begin
            for (int i = 0; i < helr_pkg::NSRC; i++)
            begin
                mem_reg[i] <= 32'h0;
            end
            rdata_o <= 32'h0;
        end
        else
        begin
            if (we_i)
            begin
                mem_reg[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_reg[raddr_i];
        end
    end
endmodule
`default_nettype wire

// ### src/helr_top.sv
/*
 * error classification, bank logging and machine-check reporting for a core.
 * assumes checkers on the core clock, an APB master on the same clock, a
 * warm reset on rst_n_i and a separate cold power-up reset on cold_n_i.
 */
`default_nettype none
module helr_top
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cold_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // error checkers and consumption
    input wire helr_pkg::helr_err_t [helr_pkg::NSRC-1:0] err_i,
    input wire helr_pkg::helr_use_t use_i,
    output helr_pkg::helr_act_t [helr_pkg::NSRC-1:0] act_o,
    // core side
    output logic machine_check_trap_o,
    output logic shutdown_o,
    output logic irq_o
);
    typedef logic [helr_pkg::NSRC-1:0] vec_t;

    // software settings and logs: reset only by cold reset, to zero except thresh, which loads all ones
    typedef struct packed {
        vec_t log_en;
        vec_t rpt_en;
        vec_t act_dis;
        vec_t poison;
        logic [helr_pkg::IRQW-1:0] stat;
        logic [helr_pkg::IRQW-1:0] mask;
        logic [helr_pkg::CNTW-1:0] thresh;
        logic [helr_pkg::CNTW-1:0] cnt;
        logic [2:0] ctrl;
        logic shut;
    } helr_cold_t;

    // bus and output state: cleared by warm reset
    typedef struct packed {
        logic ready;
        logic [31:0] rdata;
        logic trap;
        logic irq;
        helr_pkg::helr_act_t [helr_pkg::NSRC-1:0] act;
    } helr_warm_t;

    helr_cold_t c_reg, c_next;
    helr_warm_t w_reg, w_next;

    logic mem_we;
    logic [helr_pkg::SRCW-1:0] mem_waddr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;

    // pick the lowest numbered source whose class bit is set
    function automatic logic [helr_pkg::SRCW-1:0] first_src(input vec_t v);
        logic [helr_pkg::SRCW-1:0] r;
        r = '0;
        for (int i = helr_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = helr_pkg::SRCW'(i);
            end
        end
        return r;
    endfunction

    // uncorrected, deferred and corrected flags per source
    // a correctable flag wins, so a checker cannot give one error two classes
    vec_t is_unc, is_def, is_corr, is_fatal;
    genvar g;
    generate
        for (g = 0; g < helr_pkg::NSRC; g++)
        begin : g_cls
            assign is_corr[g] = err_i[g].valid && err_i[g].correctable;
            assign is_def[g] = err_i[g].valid && !err_i[g].correctable
                               && err_i[g].deferrable && !err_i[g].fatal;
            assign is_unc[g] = err_i[g].valid && !err_i[g].correctable && !is_def[g];
            assign is_fatal[g] = is_unc[g] && err_i[g].fatal;
        end
    endgenerate

    // ready high marks the answer cycle; no second take there, one answer per access
    logic apb_wr, apb_rd, bank_hit;
    assign apb_wr = psel_i && penable_i && pwrite_i && !w_reg.ready;
    assign apb_rd = psel_i && penable_i && !pwrite_i && !w_reg.ready;
    // only the bank words decode here, so offsets above them read as zero
    assign bank_hit = paddr_i[7:helr_pkg::SRCW+2] == helr_pkg::OFS_BANK0[7:helr_pkg::SRCW+2];

    // bank store for the logged error words
    // read address follows paddr_i, so the word is ready one edge after setup
    helr_log_mem u_mem
    (
        .clk_i(clk_i),
        .cold_n_i(cold_n_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(paddr_i[helr_pkg::SRCW+1:2]),
        .rdata_o(mem_rdata)
    );

    // classification, logging, reporting and register access
    always_comb
    begin
        vec_t use_vec, unc_now, ev;
        logic [1:0] cls;
        logic [helr_pkg::SRCW-1:0] s;
        logic [helr_pkg::CNTW-1:0] cnt_inc;
        logic [helr_pkg::IRQW-1:0] set, clr;
        use_vec = '0;
        unc_now = '0;
        ev = '0;
        cls = helr_pkg::CLS_NONE;
        s = '0;
        cnt_inc = '0;
        set = '0;
        clr = '0;
        c_next = c_reg;
        w_next = w_reg;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = 32'h0;
        use_vec[use_i.src] = use_i.valid;

        // correct or contain unless disabled
        // actions stand one cycle, matching the single error cycle behind them
        for (int i = 0; i < helr_pkg::NSRC; i++)
        begin
            w_next.act[i].correct = is_corr[i] && !c_reg.act_dis[i];
            w_next.act[i].contain = (is_unc[i] || is_def[i]) && !c_reg.act_dis[i];
        end

        // poisoned data escalates when consumed
        // consuming clean data is harmless and raises nothing
        unc_now = is_unc | (use_vec & c_reg.poison);

        // uncorrected beats deferred beats corrected
        // one log port, so only the most urgent event of a cycle is kept
        if (|unc_now)
        begin
            ev = unc_now;
            cls = helr_pkg::CLS_UNC;
        end
        else if (|is_def)
        begin
            ev = is_def;
            cls = helr_pkg::CLS_DEF;
        end
        else if (|is_corr)
        begin
            ev = is_corr;
            cls = helr_pkg::CLS_CORR;
        end
        s = first_src(ev);

        // log only into enabled banks, regardless of reporting
        // info comes from the chosen source's err_i, a consumption event included
        if ((|ev) && c_reg.log_en[s])
        begin
            mem_we = 1'b1;
            mem_waddr = s;
            mem_wdata = 32'h0;
            mem_wdata[helr_pkg::LOG_VALID_BIT] = 1'b1;
            mem_wdata[helr_pkg::LOG_POISON_BIT] = c_reg.poison[s] | is_def[s];
            mem_wdata[helr_pkg::LOG_CLS_LSB +: 2] = cls;
            mem_wdata[helr_pkg::INFOW-1:0] = err_i[s].info;
        end

        // mark deferred data as poisoned, drop on consumption
        // a deferral and a consumption in one cycle leave the word poisoned
        c_next.poison = (c_reg.poison & ~use_vec) | is_def;

        // one pulse, only uncorrected and only if reporting
        // the trap follows the error by one edge, so the core sees a clean pulse
        w_next.trap = (cls == helr_pkg::CLS_UNC) && c_reg.rpt_en[s];

        // uncontainable error halts the core until cold reset
        // held across warm reset, since a halted core must stay halted
        if ((|is_fatal) && c_reg.ctrl[helr_pkg::CTRL_SHUT_EN_BIT])
        begin
            c_next.shut = 1'b1;
        end

        // deferred interrupt, apart from trap enables
        // the uncorrected status bit lets polling software see errors with traps off
        set[helr_pkg::IRQ_DEF_BIT] = (|is_def) && c_reg.ctrl[helr_pkg::CTRL_DEF_EN_BIT];
        set[helr_pkg::IRQ_UNC_BIT] = cls == helr_pkg::CLS_UNC;

        // count logged corrected errors, flag on passing threshold
        // the counter saturates, so a flood never wraps and re-arms the flag
        cnt_inc = c_reg.cnt;
        if ((cls == helr_pkg::CLS_CORR) && c_reg.log_en[s] && (c_reg.cnt != '1))
        begin
            cnt_inc = c_reg.cnt + 1'b1;
        end
        c_next.cnt = cnt_inc;
        set[helr_pkg::IRQ_THR_BIT] = c_reg.ctrl[helr_pkg::CTRL_THR_EN_BIT]
                                     && (cnt_inc > c_reg.thresh)
                                     && (c_reg.cnt <= c_reg.thresh);

        // apb access: one wait state, answer in the cycle after access
        // the wait state lets every read, bank words included, leave a flop
        w_next.ready = apb_wr || apb_rd;
        w_next.rdata = 32'h0;
        if (apb_wr)
        begin
            case (paddr_i)
                helr_pkg::OFS_LOG_EN:
                begin
                    c_next.log_en = pwdata_i[helr_pkg::NSRC-1:0];
                end
                helr_pkg::OFS_RPT_EN:
                begin
                    c_next.rpt_en = pwdata_i[helr_pkg::NSRC-1:0];
                end
                helr_pkg::OFS_ACT_DIS:
                begin
                    c_next.act_dis = pwdata_i[helr_pkg::NSRC-1:0];
                end
                helr_pkg::OFS_INT_STAT:
                begin
                    // write one to clear; a same-cycle event still wins below
                    clr = pwdata_i[helr_pkg::IRQW-1:0];
                end
                helr_pkg::OFS_INT_MASK:
                begin
                    c_next.mask = pwdata_i[helr_pkg::IRQW-1:0];
                end
                helr_pkg::OFS_THRESH:
                begin
                    c_next.thresh = pwdata_i[helr_pkg::CNTW-1:0];
                end
                helr_pkg::OFS_CORR_CNT:
                begin
                    // a preload overrides any count made in the same cycle
                    c_next.cnt = pwdata_i[helr_pkg::CNTW-1:0];
                end
                helr_pkg::OFS_CTRL:
                begin
                    // the shutdown bit is read only, so three bits are kept
                    c_next.ctrl = pwdata_i[2:0];
                end
                default:
                begin
                    // bank words and unmapped offsets ignore writes
                    c_next.log_en = c_next.log_en;
                end
            endcase
        end
        if (apb_rd)
        begin
            case (paddr_i)
                helr_pkg::OFS_LOG_EN: w_next.rdata[helr_pkg::NSRC-1:0] = c_reg.log_en;
                helr_pkg::OFS_RPT_EN: w_next.rdata[helr_pkg::NSRC-1:0] = c_reg.rpt_en;
                helr_pkg::OFS_ACT_DIS: w_next.rdata[helr_pkg::NSRC-1:0] = c_reg.act_dis;
                helr_pkg::OFS_INT_STAT: w_next.rdata[helr_pkg::IRQW-1:0] = c_reg.stat;
                helr_pkg::OFS_INT_MASK: w_next.rdata[helr_pkg::IRQW-1:0] = c_reg.mask;
                helr_pkg::OFS_THRESH: w_next.rdata[helr_pkg::CNTW-1:0] = c_reg.thresh;
                helr_pkg::OFS_CORR_CNT: w_next.rdata[helr_pkg::CNTW-1:0] = c_reg.cnt;
                helr_pkg::OFS_CTRL: w_next.rdata = {28'h0, c_reg.shut, c_reg.ctrl};
                default:
                begin
                    // bank word was fetched one edge before the access edge; a log
                    // written at that very edge shows only on the next read
                    if (bank_hit)
                    begin
                        w_next.rdata = mem_rdata;
                    end
                end
            endcase
        end

        // sticky status: a new event wins over a write-one clear
        // irq uses the old mask, so a mask write takes effect one cycle later
        c_next.stat = (c_reg.stat & ~clr) | set;
        w_next.irq = |(c_next.stat & c_reg.mask);
    end

    // settings and logs reset only on cold power-up
    // a warm reset keeps them so boot code can read what caused it
    always_ff @(posedge clk_i)
    begin
        if (!cold_n_i)
        begin
            c_reg <= '0;
            c_reg.thresh <= helr_pkg::THRESH_RST;
        end
        else
        begin
            c_reg <= c_next;
        end
    end

    // bus and pulse state clears on every reset
    // pending answers and pulses are dropped, software state is not
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !cold_n_i)
        begin
            w_reg <= '0;
        end
        else
        begin
            w_reg <= w_next;
        end
    end

    assign prdata_o = w_reg.rdata;
    assign pready_o = w_reg.ready;
    // every offset answers, so the error response stays low
    assign pslverr_o = 1'b0;
    assign act_o = w_reg.act;
    assign machine_check_trap_o = w_reg.trap;
    assign shutdown_o = c_reg.shut;
    assign irq_o = w_reg.irq;
endmodule
`default_nettype wire

// ### dv/helr_asserts.sv
/*
 * port-level checks of the error log and report block.
 * assumes one core clock and warm and cold resets, both low-active and synchronous.
 */
`default_nettype none
module helr_asserts
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cold_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // checkers and core
    input wire helr_pkg::helr_err_t [helr_pkg::NSRC-1:0] err_i,
    input wire helr_pkg::helr_use_t use_i,
    input wire helr_pkg::helr_act_t [helr_pkg::NSRC-1:0] act_o,
    input wire logic machine_check_trap_o,
    input wire logic shutdown_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hard;
    logic [helr_pkg::NSRC-1:0] errv, corv, conv;
    // anything that may lawfully trap and more: any non-correctable error, deferred included, or any consumption
    always_comb
    begin
        hard = use_i.valid;
        for (int k = 0; k < helr_pkg::NSRC; k++)
        begin
            hard = hard | (err_i[k].valid & ~err_i[k].correctable);
            errv[k] = err_i[k].valid;
            corv[k] = act_o[k].correct;
            conv[k] = act_o[k].contain;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i || !cold_n_i);
    AST_TRAP_CAUSE: assert property (machine_check_trap_o |-> $past(hard))
        else $error("trap without an uncorrected cause");
    AST_ACT_CAUSE: assert property (((corv | conv) & ~$past(errv)) == '0)
        else $error("action without an error");
    AST_ACT_ONE: assert property ((corv & conv) == '0)
        else $error("error both corrected and contained");
    AST_PRDY_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer after one wait state");
    AST_PRDY_IDLE: assert property (!psel_i |=> !pready_o)
        else $error("ready without a request");
    AST_NO_SLVERR: assert property (!pslverr_o)
        else $error("slave error raised");
    // warm reset must not release a shutdown, so only cold reset disables it
    AST_SHUT_HOLD: assert property (disable iff (!cold_n_i) shutdown_o |=> shutdown_o)
        else $error("shutdown dropped before cold reset");
    AST_SHUT_CAUSE: assert property (disable iff (!cold_n_i) $rose(shutdown_o) |-> $past(hard))
        else $error("shutdown without an uncorrected error");
endmodule
`default_nettype wire

// ### dv/helr_core_model.sv
/*
 * far side model: error checkers that raise events and a core that counts traps.
 * assumes the bench calls put, consume and fire just after a rising clock edge.
 */
`default_nettype none
module helr_core_model
(
    // clock
    input wire logic clk_i,
    // from the block
    input wire logic trap_i,
    input wire helr_pkg::helr_act_t [helr_pkg::NSRC-1:0] act_i,
    // to the block
    output helr_pkg::helr_err_t [helr_pkg::NSRC-1:0] err_o,
    output helr_pkg::helr_use_t use_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int trap_cnt = 0;
    logic [7:0] act_seen = 8'h00;
    logic clr_seen = 1'b0;
    initial
    begin
        err_o = '0;
        use_o = '0;
    end
    // core side: count trap pulses, gather every action seen
    always @(posedge clk_i)
    begin
        if (trap_i === 1'b1)
            trap_cnt <= trap_cnt + 1;
        // a clear request is served here, so it never races the gathering edge
        if (clr_seen)
        begin
            act_seen <= act_i;
            clr_seen <= 1'b0;
        end
        else
        begin
            act_seen <= act_seen | act_i;
        end
    end
    // cdf is correctable, deferrable, fatal
    task automatic put(input int s, input logic [2:0] cdf, input logic [15:0] inf);
        err_o[s] <= {1'b1, cdf, inf};
    endtask
    task automatic consume(input int s);
        use_o <= {1'b1, 2'(s)};
    endtask
    task automatic clear_seen();
        clr_seen <= 1'b1;
    endtask
    // events stand one cycle only, so a level never counts twice
    task automatic fire();
        @(posedge clk_i);
        err_o <= '0;
        use_o <= '0;
    endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
/*
 * self-checking bench: apb register tasks and error event sequences.
 * assumes the block answers apb with one wait state and logs one event per cycle.
 */
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cold_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rv, b3;
    logic pready_o, pslverr_o, machine_check_trap_o, shutdown_o, irq_o;
    helr_pkg::helr_err_t [helr_pkg::NSRC-1:0] err_i;
    helr_pkg::helr_use_t use_i;
    helr_pkg::helr_act_t [helr_pkg::NSRC-1:0] act_o;
    int errors = 0;
    int n_checks = 0;
    helr_top i_helr_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .cold_n_i(cold_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .err_i(err_i), .use_i(use_i), .act_o(act_o), .machine_check_trap_o(machine_check_trap_o),
        .shutdown_o(shutdown_o), .irq_o(irq_o));
    helr_core_model i_core (.clk_i(clk_i), .trap_i(machine_check_trap_o), .act_i(act_o),
        .err_o(err_i), .use_o(use_i));
    // 40 MHz core clock
    always #12.5 clk_i = ~clk_i;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        // the wait is bounded so a dead slave shows up as a mismatch
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        `CHK(pready_o, 1'b1)
        rv = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rv, e)
    endtask
    task automatic ev(input int s, input logic [2:0] cdf, input logic [15:0] inf);
        @(posedge clk_i);
        i_core.put(s, cdf, inf);
        i_core.fire();
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [7:0] bank(input int s);
        return helr_pkg::OFS_BANK0 + 8'(4 * s);
    endfunction
    function automatic logic [31:0] lw(input logic [1:0] c, input logic p, input logic [15:0] i);
        return {1'b1, p, 12'h000, c, i};
    endfunction
    task automatic rst(input logic cold);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        cold_n_i <= ~cold;
        repeat (2) @(posedge clk_i);
        {rst_n_i, cold_n_i} <= 2'b11;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog: the tests need well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        {rst_n_i, cold_n_i} <= 2'b11;
        rd(helr_pkg::OFS_THRESH, 32'h0000FFFF);
        rd(8'h40, 32'h0);
        ev(0, 3'b100, 16'h1234);
        rd(bank(0), 32'h0);
        rd(helr_pkg::OFS_CORR_CNT, 32'h0);
        $display("test reset and disabled log done");
        wr(helr_pkg::OFS_LOG_EN, 32'hF);
        wr(helr_pkg::OFS_RPT_EN, 32'h1);
        ev(1, 3'b000, 16'h1111);
        rd(bank(1), lw(2'h2, 1'b0, 16'h1111));
        `CHK(i_core.trap_cnt, 0)
        ev(0, 3'b000, 16'h2222);
        `CHK(i_core.trap_cnt, 1)
        ev(0, 3'b100, 16'h3333);
        `CHK(i_core.trap_cnt, 1)
        rd(bank(0), lw(2'h1, 1'b0, 16'h3333));
        rd(helr_pkg::OFS_CORR_CNT, 32'h1);
        $display("test classes and reporting done");
        wr(helr_pkg::OFS_CTRL, 32'h3);
        wr(helr_pkg::OFS_INT_MASK, 32'h1);
        ev(2, 3'b010, 16'h4444);
        rd(bank(2), lw(2'h3, 1'b1, 16'h4444));
        `CHK(i_core.trap_cnt, 1)
        `CHK(irq_o, 1'b1)
        wr(helr_pkg::OFS_INT_STAT, 32'h1);
        `CHK(irq_o, 1'b0)
        wr(helr_pkg::OFS_INT_MASK, 32'h0);
        ev(3, 3'b010, 16'h5555);
        `CHK(irq_o, 1'b0)
        // the uncorrected status bit from the earlier uncorrected errors is still set
        rd(helr_pkg::OFS_INT_STAT, 32'h5);
        wr(helr_pkg::OFS_INT_STAT, 32'h1);
        wr(helr_pkg::OFS_RPT_EN, 32'h9);
        // consumption of poisoned data is the point where a deferred error escalates
        @(posedge clk_i);
        i_core.consume(3);
        i_core.fire();
        repeat (3) @(posedge clk_i);
        `CHK(i_core.trap_cnt, 2)
        @(posedge clk_i);
        i_core.consume(2);
        i_core.fire();
        repeat (3) @(posedge clk_i);
        `CHK(i_core.trap_cnt, 2)
        $display("test deferred and poison done");
        wr(helr_pkg::OFS_THRESH, 32'h1);
        wr(helr_pkg::OFS_INT_MASK, 32'h2);
        ev(3, 3'b100, 16'h6666);
        `CHK(irq_o, 1'b1)
        `CHK(i_core.trap_cnt, 2)
        wr(helr_pkg::OFS_INT_STAT, 32'h2);
        apb(1'b0, bank(3), 32'h0);
        b3 = rv;
        @(posedge clk_i);
        i_core.put(1, 3'b000, 16'h7777);
        i_core.put(3, 3'b100, 16'h8888);
        i_core.fire();
        rd(bank(1), lw(2'h2, 1'b0, 16'h7777));
        rd(bank(3), b3);
        $display("test threshold and priority done");
        wr(helr_pkg::OFS_ACT_DIS, 32'h1);
        i_core.clear_seen();
        ev(0, 3'b100, 16'h0A0A);
        `CHK(i_core.act_seen[1:0], 2'b00)
        wr(helr_pkg::OFS_ACT_DIS, 32'h0);
        ev(0, 3'b100, 16'h0B0B);
        `CHK(i_core.act_seen[1:0], 2'b10)
        wr(helr_pkg::OFS_CTRL, 32'h4);
        ev(0, 3'b001, 16'h9999);
        `CHK(shutdown_o, 1'b1)
        rst(1'b0);
        `CHK(shutdown_o, 1'b1)
        rd(bank(1), lw(2'h2, 1'b0, 16'h7777));
        rst(1'b1);
        rd(bank(1), 32'h0);
        `CHK(shutdown_o, 1'b0)
        $display("test actions, shutdown and resets done");
        report_and_stop();
    end
endmodule
bind helr_top helr_asserts i_helr_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cold_n_i(cold_n_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .err_i(err_i), .use_i(use_i), .act_o(act_o),
    .machine_check_trap_o(machine_check_trap_o), .shutdown_o(shutdown_o));
`default_nettype wire
